/* File: rtl/ddr_init_host.sv */
// Contract
// - Lane-width field 0 for one byte lane, 1 for two lanes.
// - Highest column and row bit fields get bit count minus one.
// - Bank count and burst length set to 1; burst size equals lane width.
// - ECC, both error forwards and large map kept cleared during init.
// - Refresh interval is ns over 3.2 rounded down; pending refreshes 8.
// - Precharge delays: BL-1, WL+BL+tWR-1, tRAS-1.
// - Turnarounds: RL+BL+1-WL and WL+BL+tWTR-1.
// - Init, refresh, mode-set and precharge-all delays use value minus one.
// - Load four mode values, written to memory during init.
// - Termination control register written with 0x0000000C.
// - Release pad reset and set stub mode before calibration.
// - Start impedance calibration by writing 0xEF.
// - Poll calibration bit until the device clears it.
// - After calibration enable clock, command and termination drivers.
// - Set initialize bit once configured; device runs power-up.
// - Wait for done flag before read traffic.
// - Memory-type field set to 1 for DDR3.
// - Timings are module values in 3.2 ns cycles rounded up.
// - RL is CL, WL is CWL, BL is 4, both termination offsets 2.
`timescale 1ns/1ps
module ddr_init_host #(
   parameter int POLL_LIMIT = 65536
) (
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic [7:0] I_ADDR,
   input wire logic [31:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [31:0] O_RDATA,
   output logic [7:0] O_DEV_ADDR,
   output logic [31:0] O_DEV_WDATA,
   output logic O_DEV_WR,
   output logic O_DEV_RD,
   input wire logic [31:0] I_DEV_RDATA,
   output logic O_BUSY,
   output logic O_DONE
);

   if (POLL_LIMIT < 2 || POLL_LIMIT > 32'h7fff_ffff) begin : g_check
      $error("POLL_LIMIT out of range");
   end

   localparam logic [3:0] LAST_STEP = 4'he;
   localparam logic [31:0] POLL_MAX = 32'(POLL_LIMIT - 1);

   // ----------------------------------------------------------------
   // Command registers
   // ----------------------------------------------------------------
   logic [31:0] ctrl;
   logic [31:0] lat;
   logic [31:0] rowt;
   logic [31:0] misc;
   logic [31:0] initp;
   logic done;
   logic fail;
   ddrinit_pkg::seq_e state;
   ddrinit_pkg::seq_e next_state;
   logic [3:0] step;
   logic [3:0] next_step;
   logic [31:0] poll_cnt;

   wire host_wr_ctrl = I_WR && I_ADDR == ddrinit_pkg::HOST_CTRL;
   wire start = host_wr_ctrl && I_WDATA[0] && state != ddrinit_pkg::ST_WRITE
      && state != ddrinit_pkg::ST_POLL_RD && state != ddrinit_pkg::ST_POLL_CHK;
   wire busy = state == ddrinit_pkg::ST_WRITE || state == ddrinit_pkg::ST_POLL_RD
      || state == ddrinit_pkg::ST_POLL_CHK;
   // Parameters frozen while a sequence runs, so fields stay consistent
   wire cfg_wr_ok = I_WR && !busy;

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         ctrl <= ddrinit_pkg::HOST_CTRL_RESET;
         lat <= 32'h0;
         rowt <= 32'h0;
         misc <= 32'h0;
         initp <= 32'h0;
      end else if (cfg_wr_ok) begin
         if (I_ADDR == ddrinit_pkg::HOST_CTRL) ctrl <= {I_WDATA[31:1], 1'b0};
         if (I_ADDR == ddrinit_pkg::HOST_LAT) lat <= I_WDATA;
         if (I_ADDR == ddrinit_pkg::HOST_ROW) rowt <= I_WDATA;
         if (I_ADDR == ddrinit_pkg::HOST_MISC) misc <= I_WDATA;
         if (I_ADDR == ddrinit_pkg::HOST_INIT) initp <= I_WDATA;
      end
   end

   wire [31:0] status = {24'h0, step, 1'b0, fail, done, busy};
   wire [31:0] rd_mux =
      I_ADDR == ddrinit_pkg::HOST_CTRL ? ctrl :
      I_ADDR == ddrinit_pkg::HOST_LAT ? lat :
      I_ADDR == ddrinit_pkg::HOST_ROW ? rowt :
      I_ADDR == ddrinit_pkg::HOST_MISC ? misc :
      I_ADDR == ddrinit_pkg::HOST_INIT ? initp :
      I_ADDR == ddrinit_pkg::HOST_STATUS ? status : 32'h0;

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_RDATA <= 32'h0;
      end else begin
         O_RDATA <= I_RD ? rd_mux : 32'h0;
      end
   end

   // ----------------------------------------------------------------
   // Module parameters, already in 3.2 ns cycles except the refresh interval, given in ns
   // ----------------------------------------------------------------
   wire two_lanes = ctrl[1];
   wire [31:0] col_bits = {28'h0, ctrl[7:4]};
   wire [31:0] row_bits = {27'h0, ctrl[12:8]};
   wire [31:0] rl = {24'h0, lat[7:0]};
   wire [31:0] wl = {24'h0, lat[15:8]};
   wire [31:0] twr = {24'h0, lat[23:16]};
   wire [31:0] twtr = {24'h0, lat[31:24]};
   wire [31:0] trcd = {24'h0, rowt[7:0]};
   wire [31:0] trrd = {24'h0, rowt[15:8]};
   wire [31:0] trp = {24'h0, rowt[23:16]};
   wire [31:0] tras = {24'h0, rowt[31:24]};
   wire [31:0] tfaw = {24'h0, misc[7:0]};
   wire [31:0] trc = {24'h0, misc[15:8]};
   wire [31:0] trfc = {24'h0, misc[23:16]};
   wire [31:0] tmod = {24'h0, misc[31:24]};
   wire [31:0] txpr = {22'h0, initp[9:0]};
   wire [31:0] refi_ns = {16'h0, initp[31:16]};
   wire [31:0] bl = ddrinit_pkg::BURST;

   // Floor division keeps the refresh rate at or above what the part needs
   wire [63:0] refi_ps = 64'(refi_ns) * 64'(ddrinit_pkg::PS_PER_NS);
   wire [31:0] ref_period = 32'(refi_ps / 64'(ddrinit_pkg::DEV_PERIOD_PS));

   // ----------------------------------------------------------------
   // Device register images
   // ----------------------------------------------------------------
   wire [31:0] img_cfg =
      ddrinit_pkg::fld(ddrinit_pkg::MODE_DDR3, ddrinit_pkg::CFG_MODE, 1) |
      ddrinit_pkg::fld({31'h0, two_lanes}, ddrinit_pkg::CFG_WIDTH, 1) |
      ddrinit_pkg::fld({31'h0, two_lanes}, ddrinit_pkg::CFG_BSIZE, 1) |
      ddrinit_pkg::fld(32'h1, ddrinit_pkg::CFG_BLEN, 1) |
      ddrinit_pkg::fld(32'h1, ddrinit_pkg::CFG_BANKS, 1) |
      ddrinit_pkg::fld(col_bits - 32'h1, ddrinit_pkg::CFG_COL, 4) |
      ddrinit_pkg::fld(row_bits - 32'h1, ddrinit_pkg::CFG_ROW, 4);
   wire [31:0] img_ref = ddrinit_pkg::fld(ref_period, 0, 16) |
      ddrinit_pkg::fld(ddrinit_pkg::PEND_REFRESH, ddrinit_pkg::REF_PEND, 4);
   wire [31:0] img_t0 =
      ddrinit_pkg::fld(rl - 32'h3, 0, 4) |
      ddrinit_pkg::fld(wl - 32'h1, ddrinit_pkg::T0_WR_XFR, 4) |
      ddrinit_pkg::fld(bl - 32'h1, ddrinit_pkg::T0_RD_PRE, 4) |
      ddrinit_pkg::fld(wl + bl + twr - 32'h1, ddrinit_pkg::T0_WR_PRE, 5) |
      ddrinit_pkg::fld(tras - 32'h1, ddrinit_pkg::T0_ACT_PRE, 5) |
      ddrinit_pkg::fld(bl, ddrinit_pkg::T0_RD_CS, 3) |
      ddrinit_pkg::fld(bl - 32'h1, ddrinit_pkg::T0_WR_CS, 3) |
      ddrinit_pkg::fld(rl + bl + 32'h1 - wl, ddrinit_pkg::T0_RD_WR, 4);
   wire [31:0] img_t1 =
      ddrinit_pkg::fld(wl + bl + twtr - 32'h1, 0, 5) |
      ddrinit_pkg::fld(trcd - 32'h1, ddrinit_pkg::T1_ACT_COL, 4) |
      ddrinit_pkg::fld(trrd - 32'h1, ddrinit_pkg::T1_ACT_ACT, 4) |
      ddrinit_pkg::fld(trp - 32'h1, ddrinit_pkg::T1_PRE_ACT, 4) |
      ddrinit_pkg::fld(tfaw - 32'h1, ddrinit_pkg::T1_FAW, 6) |
      ddrinit_pkg::fld(trc - 32'h1, ddrinit_pkg::T1_RC, 6);
   wire [31:0] img_t2 =
      ddrinit_pkg::fld(txpr - 32'h1, 0, 10) |
      ddrinit_pkg::fld(trfc - 32'h1, ddrinit_pkg::T2_REF, 9) |
      ddrinit_pkg::fld(tmod - 32'h1, ddrinit_pkg::T2_MODE, 5) |
      ddrinit_pkg::fld(trp - 32'h1, ddrinit_pkg::T2_PALL, 4);
   wire [31:0] img_t3 =
      ddrinit_pkg::fld(wl + twtr - 32'h1, 0, 5) |
      ddrinit_pkg::fld(rl - 32'h3, ddrinit_pkg::T3_LODT, 4) |
      ddrinit_pkg::fld(ddrinit_pkg::ODT_OFS - 32'h1, ddrinit_pkg::T3_ODT_WR, 4) |
      ddrinit_pkg::fld(ddrinit_pkg::ODT_OFS - 32'h1, ddrinit_pkg::T3_ODT_RD, 4);
   wire [31:0] img_mr0 = ddrinit_pkg::fld(rl - 32'h4, 4, 3) |
      ddrinit_pkg::fld(twr - 32'h4, 9, 3);
   wire [31:0] img_mr2 = ddrinit_pkg::fld(wl - 32'h5, 3, 3);
   wire [31:0] img_phy_on = 32'h1 << ddrinit_pkg::PHY_STUB;
   wire [31:0] img_phy_oe = img_phy_on | (32'h1 << ddrinit_pkg::MEMORY_CLOCK_DRIVE_ENABLE) |
      (32'h1 << ddrinit_pkg::COMMAND_LINES_DRIVE_ENABLE) | (32'h1 << ddrinit_pkg::TERMINATION_DRIVE_ENABLE);

   // ----------------------------------------------------------------
   // Step table: one device write per step, some followed by a poll
   // ----------------------------------------------------------------
   wire [7:0] step_addr =
      step == 4'h0 ? ddrinit_pkg::DEV_CFG :
      step == 4'h1 ? ddrinit_pkg::DEV_REF :
      step == 4'h2 ? ddrinit_pkg::DEV_T0 :
      step == 4'h3 ? ddrinit_pkg::DEV_T1 :
      step == 4'h4 ? ddrinit_pkg::DEV_T2 :
      step == 4'h5 ? ddrinit_pkg::DEV_T3 :
      step == 4'h6 ? ddrinit_pkg::DEV_MR0 :
      step == 4'h7 ? ddrinit_pkg::DEV_MR1 :
      step == 4'h8 ? ddrinit_pkg::DEV_MR2 :
      step == 4'h9 ? ddrinit_pkg::DEV_MR3 :
      step == 4'ha ? ddrinit_pkg::DEV_TERM :
      step == 4'hb ? ddrinit_pkg::DEV_PHY :
      step == 4'hc ? ddrinit_pkg::DEV_ZCAL :
      step == 4'hd ? ddrinit_pkg::DEV_PHY : ddrinit_pkg::DEV_CMD;
   wire [31:0] step_data =
      step == 4'h0 ? img_cfg :
      step == 4'h1 ? img_ref :
      step == 4'h2 ? img_t0 :
      step == 4'h3 ? img_t1 :
      step == 4'h4 ? img_t2 :
      step == 4'h5 ? img_t3 :
      step == 4'h6 ? img_mr0 :
      step == 4'h7 ? ddrinit_pkg::MR1_FIXED :
      step == 4'h8 ? img_mr2 :
      step == 4'h9 ? ddrinit_pkg::MR3_FIXED :
      step == 4'ha ? ddrinit_pkg::TERM_ALL_WRITES :
      step == 4'hb ? img_phy_on :
      step == 4'hc ? ddrinit_pkg::ZCAL_START :
      step == 4'hd ? img_phy_oe : 32'h1 << ddrinit_pkg::CMD_INIT;
   wire step_polls = step == 4'hc || step == LAST_STEP;
   wire [7:0] poll_addr = step == 4'hc ? ddrinit_pkg::DEV_ZCAL : ddrinit_pkg::DEV_STATE;
   // Calibration ends when the device clears its bit; init ends on done
   wire poll_ok = step == 4'hc ? !I_DEV_RDATA[ddrinit_pkg::ZCAL_ACTIVE]
      : I_DEV_RDATA[ddrinit_pkg::STATE_DONE];
   wire poll_out = poll_cnt == POLL_MAX;

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_step = step;
      case (state)
         ddrinit_pkg::ST_IDLE,
         ddrinit_pkg::ST_DONE,
         ddrinit_pkg::ST_FAIL: begin
            if (start) begin
               next_state = ddrinit_pkg::ST_WRITE;
               next_step = 4'h0;
            end
         end
         ddrinit_pkg::ST_WRITE: begin
            if (step_polls) begin
               next_state = ddrinit_pkg::ST_POLL_RD;
            end else begin
               next_step = step + 4'h1;
            end
         end
         ddrinit_pkg::ST_POLL_RD: begin
            next_state = ddrinit_pkg::ST_POLL_CHK;
         end
         ddrinit_pkg::ST_POLL_CHK: begin
            if (poll_ok && step == LAST_STEP) begin
               next_state = ddrinit_pkg::ST_DONE;
            end else if (poll_ok) begin
               next_state = ddrinit_pkg::ST_WRITE;
               next_step = step + 4'h1;
            end else if (poll_out) begin
               next_state = ddrinit_pkg::ST_FAIL;
            end else begin
               next_state = ddrinit_pkg::ST_POLL_RD;
            end
         end
         default: begin
            next_state = ddrinit_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         state <= ddrinit_pkg::ST_IDLE;
         step <= 4'h0;
         poll_cnt <= 32'h0;
         done <= 1'b0;
         fail <= 1'b0;
      end else begin
         state <= next_state;
         step <= next_step;
         poll_cnt <= state == ddrinit_pkg::ST_POLL_CHK ? poll_cnt + 32'h1 :
            state == ddrinit_pkg::ST_WRITE ? 32'h0 : poll_cnt;
         done <= next_state == ddrinit_pkg::ST_DONE;
         fail <= next_state == ddrinit_pkg::ST_FAIL;
      end
   end

   // Device bus outputs registered from the current state; busy and done from the next state
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_DEV_ADDR <= 8'h0;
         O_DEV_WDATA <= 32'h0;
         O_DEV_WR <= 1'b0;
         O_DEV_RD <= 1'b0;
         O_BUSY <= 1'b0;
         O_DONE <= 1'b0;
      end else begin
         O_DEV_WR <= state == ddrinit_pkg::ST_WRITE;
         O_DEV_RD <= state == ddrinit_pkg::ST_POLL_RD;
         O_DEV_ADDR <= state == ddrinit_pkg::ST_POLL_RD ? poll_addr : step_addr;
         O_DEV_WDATA <= state == ddrinit_pkg::ST_WRITE ? step_data : 32'h0;
         O_BUSY <= next_state == ddrinit_pkg::ST_WRITE
            || next_state == ddrinit_pkg::ST_POLL_RD || next_state == ddrinit_pkg::ST_POLL_CHK;
         O_DONE <= next_state == ddrinit_pkg::ST_DONE;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   wire wr_cfg = O_DEV_WR && O_DEV_ADDR == ddrinit_pkg::DEV_CFG;

   sequence s_zcal_start;
      O_DEV_WR && O_DEV_ADDR == ddrinit_pkg::DEV_ZCAL;
   endsequence
   sequence s_poll_zcal;
      O_DEV_RD && O_DEV_ADDR == ddrinit_pkg::DEV_ZCAL;
   endsequence

   term_value_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      O_DEV_WR && O_DEV_ADDR == ddrinit_pkg::DEV_TERM |-> O_DEV_WDATA == 32'h0000_000c)
      else $error("termination control value wrong");

   zcal_value_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      s_zcal_start |-> O_DEV_WDATA == 32'h0000_00ef)
      else $error("calibration start value wrong");

   zcal_poll_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      s_zcal_start |=> s_poll_zcal)
      else $error("calibration not polled after start");

   oe_after_cal_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      s_poll_zcal ##0 !I_DEV_RDATA[0] |=> ##1 O_DEV_WR && O_DEV_ADDR == ddrinit_pkg::DEV_PHY
      && O_DEV_WDATA[4:1] == 4'hf)
      else $error("drivers not enabled after calibration");

   lane_burst_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      wr_cfg |-> O_DEV_WDATA[2] == O_DEV_WDATA[1] && O_DEV_WDATA[4:3] == 2'b11
      && O_DEV_WDATA[1] == $past(ctrl[1]))
      else $error("configuration lane or burst fields wrong");

   ecc_clear_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      wr_cfg |-> O_DEV_WDATA[16:13] == 4'h0 && O_DEV_WDATA[0])
      else $error("ecc or map bit set during init");

   pend_ref_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      O_DEV_WR && O_DEV_ADDR == ddrinit_pkg::DEV_REF |-> O_DEV_WDATA[19:16] == 4'h8)
      else $error("pending refresh count wrong");

   init_poll_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      O_DEV_WR && O_DEV_ADDR == ddrinit_pkg::DEV_CMD |=> O_DEV_RD
      && O_DEV_ADDR == ddrinit_pkg::DEV_STATE)
      else $error("init not followed by status poll");

   done_cause_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      $rose(O_DONE) |-> $past(O_DEV_RD) && $past(O_DEV_ADDR) == ddrinit_pkg::DEV_STATE
      && $past(I_DEV_RDATA[0]))
      else $error("done without device done flag");

   one_strobe_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      !(O_DEV_WR && O_DEV_RD))
      else $error("both device strobes high");

endmodule

/* File: rtl/ddrinit_pkg.sv */
package ddrinit_pkg;

   // ----------------------------------------------------------------
   // Device register map, byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] DEV_CFG = 8'h00;
   localparam logic [7:0] DEV_REF = 8'h04;
   localparam logic [7:0] DEV_T0 = 8'h08;
   localparam logic [7:0] DEV_T1 = 8'h0c;
   localparam logic [7:0] DEV_T2 = 8'h10;
   localparam logic [7:0] DEV_T3 = 8'h14;
   localparam logic [7:0] DEV_MR0 = 8'h18;
   localparam logic [7:0] DEV_MR1 = 8'h1c;
   localparam logic [7:0] DEV_MR2 = 8'h20;
   localparam logic [7:0] DEV_MR3 = 8'h24;
   localparam logic [7:0] DEV_TERM = 8'h28;
   localparam logic [7:0] DEV_PHY = 8'h2c;
   localparam logic [7:0] DEV_ZCAL = 8'h30;
   localparam logic [7:0] DEV_CMD = 8'h34;
   localparam logic [7:0] DEV_STATE = 8'h38;

   // ----------------------------------------------------------------
   // Host command registers
   // ----------------------------------------------------------------
   localparam logic [7:0] HOST_CTRL = 8'h00;
   localparam logic [7:0] HOST_LAT = 8'h04;
   localparam logic [7:0] HOST_ROW = 8'h08;
   localparam logic [7:0] HOST_MISC = 8'h0c;
   localparam logic [7:0] HOST_INIT = 8'h10;
   localparam logic [7:0] HOST_STATUS = 8'h14;
   localparam logic [31:0] HOST_CTRL_RESET = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Device field positions
   // ----------------------------------------------------------------
   localparam int CFG_MODE = 0;
   localparam int CFG_WIDTH = 1;
   localparam int CFG_BSIZE = 2;
   localparam int CFG_BLEN = 3;
   localparam int CFG_BANKS = 4;
   localparam int CFG_COL = 5;
   localparam int CFG_ROW = 9;
   localparam int CFG_ECC = 13;
   localparam int CFG_ECC_COR = 14;
   localparam int CFG_ECC_ERR = 15;
   localparam int CFG_LARGE = 16;
   localparam int REF_PEND = 16;
   localparam int T0_WR_XFR = 4;
   localparam int T0_RD_PRE = 8;
   localparam int T0_WR_PRE = 12;
   localparam int T0_ACT_PRE = 17;
   localparam int T0_RD_CS = 22;
   localparam int T0_WR_CS = 25;
   localparam int T0_RD_WR = 28;
   localparam int T1_ACT_COL = 5;
   localparam int T1_ACT_ACT = 9;
   localparam int T1_PRE_ACT = 13;
   localparam int T1_FAW = 17;
   localparam int T1_RC = 23;
   localparam int T2_REF = 10;
   localparam int T2_MODE = 19;
   localparam int T2_PALL = 24;
   localparam int T3_LODT = 5;
   localparam int T3_ODT_WR = 9;
   localparam int T3_ODT_RD = 13;
   localparam int PAD_INTERFACE_RESET = 0;
   localparam int PHY_STUB = 1;
   localparam int MEMORY_CLOCK_DRIVE_ENABLE = 2;
   localparam int COMMAND_LINES_DRIVE_ENABLE = 3;
   localparam int TERMINATION_DRIVE_ENABLE = 4;
   localparam int ZCAL_ACTIVE = 0;
   localparam int CMD_INIT = 0;
   localparam int STATE_DONE = 0;

   // ----------------------------------------------------------------
   // Fixed values and timing
   // ----------------------------------------------------------------
   localparam logic [31:0] MODE_DDR3 = 32'h0000_0001;
   localparam logic [31:0] PEND_REFRESH = 32'h0000_0008;
   localparam logic [31:0] BURST = 32'h0000_0004;
   localparam logic [31:0] ODT_OFS = 32'h0000_0002;
   localparam logic [31:0] MR1_FIXED = 32'h0000_0040;
   localparam logic [31:0] MR3_FIXED = 32'h0000_0000;
   localparam logic [31:0] TERM_ALL_WRITES = 32'h0000_000c;
   localparam logic [31:0] ZCAL_START = 32'h0000_00ef;
   localparam int DEV_PERIOD_PS = 3200;
   localparam int PS_PER_NS = 1000;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_WRITE = 3'b001,
      ST_POLL_RD = 3'b010,
      ST_POLL_CHK = 3'b011,
      ST_DONE = 3'b100,
      ST_FAIL = 3'b101
   } seq_e;

   // Value masked to its field width, shifted to its position
   function automatic logic [31:0] fld(input logic [31:0] v, input int lsb, input int w);
      fld = (v & ((32'h1 << w) - 32'h1)) << lsb;
   endfunction

endpackage

/* File: tb/ddr_dev_model.sv */
`timescale 1ns/1ps
module ddr_dev_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic i_stuck
);
   logic [31:0] regs [0:15];
   logic [31:0] idle_q;
   logic [7:0] log_a [0:31];
   logic [31:0] log_d [0:31];
   int log_n;
   int zcal_cnt;
   int init_cnt;
   // ----------------------------------------------------------------
   // Register file with self-timed calibration and power-up
   // ----------------------------------------------------------------
   // Host checks the answer in the strobe cycle, so reads are combinational
   always_comb rdata = rd ? regs[addr[5:2]] : idle_q;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         idle_q <= 32'h0;
         log_n <= 0;
         zcal_cnt <= 0;
         init_cnt <= 0;
         for (int k = 0; k < 16; k++) regs[k] <= 32'h0;
      end else begin
         // Idle bus toggles so a late sample never looks valid
         idle_q <= ~idle_q;
         if (zcal_cnt > 0 && !i_stuck) begin
            zcal_cnt <= zcal_cnt - 1;
            if (zcal_cnt == 1) regs[12][0] <= 1'b0;
         end
         if (init_cnt > 0) begin
            init_cnt <= init_cnt - 1;
            if (init_cnt == 1) begin
               regs[13][0] <= 1'b0;
               regs[14][0] <= 1'b1;
            end
         end
         if (wr) begin
            regs[addr[5:2]] <= wdata;
            log_a[addr == 8'h00 ? 0 : log_n] <= addr;
            log_d[addr == 8'h00 ? 0 : log_n] <= wdata;
            log_n <= (addr == 8'h00) ? 1 : log_n + 1;
            if (addr == ddrinit_pkg::DEV_ZCAL) zcal_cnt <= 4;
            if (addr == ddrinit_pkg::DEV_CMD && wdata[0]) begin
               init_cnt <= 10;
               regs[14][0] <= 1'b0;
            end
         end
      end
   end
endmodule

/* File: tb/ddr_init_host_tb_top.sv */
`timescale 1ns/1ps
module ddr_init_host_tb_top;
   logic I_CLK, I_RST, I_WR, I_RD, O_BUSY, O_DONE, dev_wr, dev_rd, stuck;
   logic [7:0] I_ADDR, dev_addr;
   logic [31:0] I_WDATA, O_RDATA, dev_wdata, dev_rdata, rd_val;
   logic [31:0] exp [0:11];
   int bad_count = 0;
   int n_tests = 0;
   int cl = 6, cwl = 5, twr = 5, twtr = 3, bl = 4, trcd = 5, trrd = 4, trp = 5;
   int tras = 12, tfaw = 20, trc = 17, trfc = 35, tmod = 12, txpr = 40;

   ddr_init_host #(.POLL_LIMIT(8)) i_ddr_init_host (.I_CLK(I_CLK), .I_RST(I_RST),
      .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
      .O_DEV_ADDR(dev_addr), .O_DEV_WDATA(dev_wdata), .O_DEV_WR(dev_wr), .O_DEV_RD(dev_rd),
      .I_DEV_RDATA(dev_rdata), .O_BUSY(O_BUSY), .O_DONE(O_DONE));
   ddr_dev_model i_ddr_dev_model (.clk(I_CLK), .rst(I_RST), .addr(dev_addr),
      .wdata(dev_wdata), .wr(dev_wr), .rd(dev_rd), .rdata(dev_rdata), .i_stuck(stuck));

   initial begin
      I_CLK = 1'b0;
      forever #20 I_CLK = ~I_CLK;
   end
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
      n_tests++;
      if (seen !== want) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic tally_and_finish;
      $display("Checks %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic hwr(input logic [7:0] a, input logic [31:0] d);
      @(posedge I_CLK);
      I_WR <= 1'b1;
      I_ADDR <= a;
      I_WDATA <= d;
      @(posedge I_CLK);
      I_WR <= 1'b0;
   endtask
   task automatic hrd(input logic [7:0] a);
      @(posedge I_CLK);
      I_RD <= 1'b1;
      I_ADDR <= a;
      @(posedge I_CLK);
      I_RD <= 1'b0;
      #1 rd_val = O_RDATA;
   endtask
   task automatic run_seq(input int two, input int drop_write);
      int k;
      exp[0] = 1 | two << 1 | two << 2 | 1 << 3 | 1 << 4 | 9 << 5 | 13 << 9;
      exp[1] = (7800 * 10 / 32) | 8 << 16;
      exp[2] = (cl - 3) | (cwl - 1) << 4 | (bl - 1) << 8 | (cwl + bl + twr - 1) << 12
         | (tras - 1) << 17 | bl << 22 | (bl - 1) << 25 | (cl + bl + 1 - cwl) << 28;
      exp[3] = (cwl + bl + twtr - 1) | (trcd - 1) << 5 | (trrd - 1) << 9 | (trp - 1) << 13
         | (tfaw - 1) << 17 | (trc - 1) << 23;
      exp[4] = (txpr - 1) | (trfc - 1) << 10 | (tmod - 1) << 19 | (trp - 1) << 24;
      exp[5] = (cwl + twtr - 1) | (cl - 3) << 5 | (2 - 1) << 9 | (2 - 1) << 13;
      exp[6] = (cl - 4) << 4 | (twr - 4) << 9;
      exp[7] = 32'h40;
      exp[8] = (cwl - 5) << 3;
      exp[9] = 32'h0;
      exp[10] = 32'hc;
      hwr(ddrinit_pkg::HOST_CTRL, two << 1 | 10 << 4 | 14 << 8);
      hwr(ddrinit_pkg::HOST_LAT, cl | cwl << 8 | twr << 16 | twtr << 24);
      hwr(ddrinit_pkg::HOST_ROW, trcd | trrd << 8 | trp << 16 | tras << 24);
      hwr(ddrinit_pkg::HOST_MISC, tfaw | trc << 8 | trfc << 16 | tmod << 24);
      hwr(ddrinit_pkg::HOST_INIT, txpr | 7800 << 16);
      hwr(ddrinit_pkg::HOST_CTRL, two << 1 | 10 << 4 | 14 << 8 | 1);
      repeat (3) @(posedge I_CLK);
      chk("busy", O_BUSY, 1'b1);
      if (drop_write) hwr(ddrinit_pkg::HOST_LAT, 32'h0);
      k = 0;
      while (O_BUSY !== 1'b0 && k < 2000) begin
         @(posedge I_CLK);
         k++;
      end
      if (k >= 2000) begin
         bad_count++;
         tally_and_finish();
      end
      // Drivers stay off when calibration never finishes
      exp[11] = stuck ? 32'h2 : 32'h1e;
      for (int r = 0; r < 12; r++) chk("dev reg", i_ddr_dev_model.regs[r], exp[r]);
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic sc_reset;
      hrd(ddrinit_pkg::HOST_STATUS);
      chk("status", rd_val, 32'h0);
      hrd(8'h40);
      chk("unmapped", rd_val, 32'h0);
   endtask
   task automatic sc_init(input int two);
      run_seq(two, two == 0);
      chk("done", O_DONE, 1'b1);
      hrd(ddrinit_pkg::HOST_STATUS);
      chk("status", rd_val[2:0], 3'b010);
      chk("writes", i_ddr_dev_model.log_n, 15);
      for (int k = 0; k < 13; k++) chk("order", i_ddr_dev_model.log_a[k], k * 4);
      chk("zcal", i_ddr_dev_model.log_d[12], 32'hef);
      chk("pads", i_ddr_dev_model.log_d[13], 32'h1e);
      chk("cmd", i_ddr_dev_model.log_d[14], 32'h1);
      chk("cmd clr", i_ddr_dev_model.regs[13][0], 1'b0);
   endtask
   task automatic sc_timeout;
      stuck <= 1'b1;
      run_seq(0, 0);
      chk("no done", O_DONE, 1'b0);
      hrd(ddrinit_pkg::HOST_STATUS);
      chk("fail", rd_val[2:0], 3'b100);
      chk("no pads", i_ddr_dev_model.log_n, 13);
      stuck <= 1'b0;
   endtask

   initial begin
      I_RST = 1'b1;
      I_WR = 1'b0;
      I_RD = 1'b0;
      I_ADDR = 8'h0;
      I_WDATA = 32'h0;
      stuck = 1'b0;
      repeat (12) @(posedge I_CLK);
      I_RST <= 1'b0;
      sc_reset();
      sc_init(1);
      sc_init(0);
      sc_timeout();
      sc_init(1);
      tally_and_finish();
   end
endmodule
